// file: logic/ncirq_top.sv
// Notes on behaviour
// - Flash-side receive push underrun or misalignment sets source bit 8.
// - Bus-side receive pop underrun or misalignment sets source bit 7.
// - Bus-side transmit push overrun or misalignment sets source bit 6.
// - Receive FIFO becoming full sets source bit 5.
// - Receive level rising above its threshold sets source bit 4.
// - Receive FIFO becoming not empty sets source bit 3.
// - Transmit FIFO becoming not full sets source bit 2.
// - Transmit free space rising above its threshold sets source bit 1.
// - Transmit FIFO becoming empty sets source bit 0.
// - Mask bit per source; one blocks, zero passes.
// - All mask bits are one after reset.
// - Writing one to a clear bit clears that source unless its event fires in the same cycle; zero leaves it.
// - The raw source register is readable at any time.
// - Interrupt is high while any unmasked source bit is set.
// - Flash-side transmit pop overrun or misalignment sets source bit 9.
// - Block read, block write and ECC completions set bits 10 to 14.
`timescale 1ns/1ps
`default_nettype none
module ncirq_top (
  input  wire logic        mclk_in,            // System clock, 250 MHz.
  input  wire logic        srst_in,            // Sync reset, active high.
  input  wire logic [7:0]  addr_in,            // Register byte address.
  input  wire logic [31:0] wdata_in,           // Write data.
  input  wire logic        wr_in,              // Write strobe.
  input  wire logic        rd_in,              // Read strobe.
  output logic      [31:0] rdata_out,          // Read data, cycle after strobe.
  output logic             irq_out,            // Level interrupt.
  input  wire logic        rx_full_in,         // Receive FIFO full level.
  input  wire logic        rx_empty_in,        // Receive FIFO empty level.
  input  wire logic        tx_full_in,         // Transmit FIFO full level.
  input  wire logic        tx_empty_in,        // Transmit FIFO empty level.
  input  wire logic [11:0] rx_level_in,        // Receive bytes held.
  input  wire logic [11:0] tx_space_in,        // Transmit free bytes.
  input  wire logic        bus_push_ovr_in,    // Bus write into full transmit FIFO.
  input  wire logic        bus_pop_und_in,     // Bus read from empty receive FIFO.
  input  wire logic        bus_acc_in,         // Bus FIFO access strobe.
  input  wire logic        bus_acc_dir_in,     // One for transmit push, zero for pop.
  input  wire logic        bus_acc_word_in,    // Access is a 32-bit word.
  input  wire logic [1:0]  bus_byte_ptr_in,    // FIFO byte pointer before access.
  input  wire logic        ext_push_err_in,    // Flash-side receive push error.
  input  wire logic        ext_pop_err_in,     // Flash-side transmit pop error.
  input  wire logic        blk_read_done_in,   // Block read completed.
  input  wire logic        blk_write_done_in,  // Block write completed.
  input  wire logic        par_ready_in,       // Write parity ready.
  input  wire logic        ecc_check_done_in,  // Read ECC check done.
  input  wire logic        corr_data_done_in   // Corrected data written.
);
  localparam int unsigned W = ncirq_pkg::SRC_W;

  ncirq_evt_if evt ();

  logic [31:0]  mask;
  logic [31:0]  thresh;
  logic [5:0]   fifo_pulse;
  logic         misaligned;
  logic [W-1:0] next_clear;
  logic [W-1:0] event_all;

  ncirq_edge u_edge (
    .mclk_in      (mclk_in),
    .srst_in      (srst_in),
    .rx_full_in   (rx_full_in),
    .rx_empty_in  (rx_empty_in),
    .tx_full_in   (tx_full_in),
    .tx_empty_in  (tx_empty_in),
    .rx_level_in  (rx_level_in),
    .tx_space_in  (tx_space_in),
    .rx_thresh_in (thresh[27:16]),
    .tx_thresh_in (thresh[11:0]),
    .pulse_out    (fifo_pulse)
  );

  // A word access with the pointer off byte zero splits a word across two slots.
  assign misaligned = bus_acc_in && bus_acc_word_in && (bus_byte_ptr_in != 2'h0);

  always_comb begin
    event_all = {W{1'b0}};
    event_all[5:0] = fifo_pulse;
    event_all[ncirq_pkg::BIT_BUS_PUSH] = bus_push_ovr_in
                                         || (misaligned && bus_acc_dir_in);
    event_all[ncirq_pkg::BIT_BUS_POP]  = bus_pop_und_in
                                         || (misaligned && !bus_acc_dir_in);
    event_all[ncirq_pkg::BIT_EXT_PUSH] = ext_push_err_in;
    event_all[ncirq_pkg::BIT_EXT_POP]  = ext_pop_err_in;
    event_all[10] = blk_read_done_in;
    event_all[11] = blk_write_done_in;
    event_all[12] = par_ready_in;
    event_all[13] = ecc_check_done_in;
    event_all[14] = corr_data_done_in;
  end

  assign evt.event_pulse = event_all;
  assign next_clear = (wr_in && addr_in == ncirq_pkg::OFF_CLEAR) ? wdata_in[W-1:0]
                                                                  : {W{1'b0}};
  assign evt.clear_bits = next_clear;

  // One sticky flop per source; the set term is applied after the clear.
  genvar g;
  logic [W-1:0] src_q;
  generate
    for (g = 0; g < W; g++) begin : g_src
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          src_q[g] <= ncirq_pkg::SOURCE_RESET[g];
        end else if (evt.event_pulse[g]) begin
          src_q[g] <= 1'b1;
        end else if (evt.clear_bits[g]) begin
          src_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign evt.source = src_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mask <= ncirq_pkg::MASK_RESET;
    end else if (wr_in && addr_in == ncirq_pkg::OFF_MASK) begin
      mask <= {17'h00000, wdata_in[W-1:0]};
    end
  end

  // Thresholds: receive in bits 27..16, transmit in bits 11..0.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      thresh <= ncirq_pkg::THRESH_RESET;
    end else if (wr_in && addr_in == ncirq_pkg::OFF_THRESH) begin
      thresh <= {4'h0, wdata_in[27:16], 4'h0, wdata_in[11:0]};
    end
  end

  // The interrupt reflects the state before this edge's update, two cycles behind events.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt.source & ~mask[W-1:0]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      unique case (addr_in)
        ncirq_pkg::OFF_SOURCE: rdata_out <= {17'h00000, evt.source};
        ncirq_pkg::OFF_MASK:   rdata_out <= {17'h00000, mask[W-1:0]};
        ncirq_pkg::OFF_THRESH: rdata_out <= thresh;
        default:               rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  property p_event_sets;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && evt.event_pulse[10] |=> evt.source[10];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set source");

  property p_set_wins;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (evt.event_pulse & evt.clear_bits) != {W{1'b0}}
        |=> (evt.source & $past(evt.event_pulse)) == $past(evt.event_pulse);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat event");

  property p_clear;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (evt.clear_bits[8] && !evt.event_pulse[8]) |=> !evt.source[8];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_hold;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (evt.source[9] && !evt.clear_bits[9]) |=> evt.source[9];
  endproperty
  a_hold: assert property (p_hold) else $error("source bit lost");

  property p_irq;
    @(posedge mclk_in) disable iff (srst_in)
      !$past(srst_in) |-> irq_out == $past(|(evt.source & ~mask[W-1:0]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_mask_reset;
    @(posedge mclk_in) $fell(srst_in) |-> mask[W-1:0] == 15'h7FFF && !irq_out;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not set after reset");

  property p_reserved;
    @(posedge mclk_in) disable iff (srst_in)
      rdata_out[31:15] == 17'h00000 || $past(addr_in) == ncirq_pkg::OFF_THRESH;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_misalign;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (misaligned && bus_acc_dir_in) |=> evt.source[ncirq_pkg::BIT_BUS_PUSH];
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned push missed");

  property p_read_src;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (rd_in && addr_in == ncirq_pkg::OFF_SOURCE)
        |=> rdata_out[W-1:0] == $past(evt.source);
  endproperty
  a_read_src: assert property (p_read_src) else $error("source read wrong");

  // Antecedents other than p_reset_state and p_irq demand reset low in the sampled cycle (p_irq demands it low in the cycle before),
  // so a mid-run reset never feeds the state from before the reset into a check that looks one cycle later.
  property p_ext_push;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && ext_push_err_in |=> evt.source[ncirq_pkg::BIT_EXT_PUSH];
  endproperty
  a_ext_push: assert property (p_ext_push) else $error("flash push error lost");

  property p_ext_pop;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && ext_pop_err_in |=> evt.source[ncirq_pkg::BIT_EXT_POP];
  endproperty
  a_ext_pop: assert property (p_ext_pop) else $error("flash pop error lost");

  property p_bus_push;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && bus_push_ovr_in |=> evt.source[ncirq_pkg::BIT_BUS_PUSH];
  endproperty
  a_bus_push: assert property (p_bus_push) else $error("bus push error lost");

  property p_bus_pop;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && bus_pop_und_in |=> evt.source[ncirq_pkg::BIT_BUS_POP];
  endproperty
  a_bus_pop: assert property (p_bus_pop) else $error("bus pop error lost");

  property p_misalign_pop;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && (misaligned && !bus_acc_dir_in) |=> evt.source[ncirq_pkg::BIT_BUS_POP];
  endproperty
  a_misalign_pop: assert property (p_misalign_pop) else $error("misaligned pop lost");

  property p_byte_access;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && bus_acc_in && !bus_acc_word_in && !bus_push_ovr_in && !bus_pop_und_in
        |-> evt.event_pulse[7:6] == 2'h0;
  endproperty
  a_byte_access: assert property (p_byte_access) else $error("byte access flagged");

  property p_rx_full;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && $rose(rx_full_in) |=> evt.source[ncirq_pkg::BIT_RX_FULL];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive full lost");

  property p_rx_thresh;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && (rx_level_in > thresh[27:16])
        && !$past(rx_level_in > thresh[27:16]) |=> evt.source[ncirq_pkg::BIT_RX_THRESH];
  endproperty
  a_rx_thresh: assert property (p_rx_thresh) else $error("receive level lost");

  property p_rx_nonempty;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && $fell(rx_empty_in)
        |=> evt.source[ncirq_pkg::BIT_RX_NONEMPTY];
  endproperty
  a_rx_nonempty: assert property (p_rx_nonempty) else $error("receive fill lost");

  property p_tx_nonfull;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && $fell(tx_full_in)
        |=> evt.source[ncirq_pkg::BIT_TX_NONFULL];
  endproperty
  a_tx_nonfull: assert property (p_tx_nonfull) else $error("transmit space lost");

  property p_tx_thresh;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && (tx_space_in > thresh[11:0])
        && !$past(tx_space_in > thresh[11:0]) |=> evt.source[ncirq_pkg::BIT_TX_THRESH];
  endproperty
  a_tx_thresh: assert property (p_tx_thresh) else $error("transmit level lost");

  property p_tx_empty;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !$past(srst_in) && $rose(tx_empty_in) |=> evt.source[ncirq_pkg::BIT_TX_EMPTY];
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("transmit empty lost");

  property p_steady_levels;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && $stable({rx_full_in, rx_empty_in, tx_full_in, tx_empty_in})
        && $stable({rx_level_in, tx_space_in, thresh}) |-> fifo_pulse == 6'h00;
  endproperty
  a_steady_levels: assert property (p_steady_levels) else $error("level refired");

  property p_blk_write;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && blk_write_done_in |=> evt.source[11];
  endproperty
  a_blk_write: assert property (p_blk_write) else $error("block write lost");

  property p_ecc_events;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in |=> (~evt.source[14:12]
        & $past({corr_data_done_in, ecc_check_done_in, par_ready_in})) == 3'h0;
  endproperty
  a_ecc_events: assert property (p_ecc_events) else $error("ecc event lost");

  property p_mask_write;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && wr_in && addr_in == ncirq_pkg::OFF_MASK
        |=> mask[W-1:0] == $past(wdata_in[W-1:0]) && mask[31:15] == 17'h00000;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

  property p_clear_ones;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && wr_in && addr_in == ncirq_pkg::OFF_CLEAR
        |=> (evt.source & $past(wdata_in[W-1:0] & ~evt.event_pulse)) == {W{1'b0}};
  endproperty
  a_clear_ones: assert property (p_clear_ones) else $error("clear ignored");

  property p_clear_zeros;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && wr_in && addr_in == ncirq_pkg::OFF_CLEAR
        |=> ($past(evt.source & ~wdata_in[W-1:0]) & ~evt.source) == {W{1'b0}};
  endproperty
  a_clear_zeros: assert property (p_clear_zeros) else $error("zero write cleared");

  property p_no_spurious;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in |=> (evt.source & ~$past(evt.source) & ~$past(evt.event_pulse)) == {W{1'b0}};
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("source set alone");

  property p_read_mask;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && rd_in && addr_in == ncirq_pkg::OFF_MASK
        |=> rdata_out == {17'h00000, $past(mask[W-1:0])};
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read wrong");

  property p_rdata_idle;
    @(posedge mclk_in) disable iff (srst_in)
      !srst_in && !rd_in |=> rdata_out == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_reset_state;
    @(posedge mclk_in) srst_in |=> evt.source == {W{1'b0}} && !irq_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule
`default_nettype wire

// file: logic/ncirq_pkg.sv
`default_nettype none
package ncirq_pkg;
  localparam int unsigned SRC_W = 15;
  localparam logic [7:0] OFF_SOURCE = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_CLEAR  = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h64;
  localparam logic [31:0] MASK_RESET = 32'h0FFFFFFF;
  localparam logic [14:0] SOURCE_RESET = 15'h0000;
  localparam logic [31:0] THRESH_RESET = 32'h00000000;
  localparam int unsigned LEVEL_W = 12;
  localparam int unsigned BIT_TX_EMPTY    = 0;
  localparam int unsigned BIT_TX_THRESH   = 1;
  localparam int unsigned BIT_TX_NONFULL  = 2;
  localparam int unsigned BIT_RX_NONEMPTY = 3;
  localparam int unsigned BIT_RX_THRESH   = 4;
  localparam int unsigned BIT_RX_FULL     = 5;
  localparam int unsigned BIT_BUS_PUSH    = 6;
  localparam int unsigned BIT_BUS_POP     = 7;
  localparam int unsigned BIT_EXT_PUSH    = 8;
  localparam int unsigned BIT_EXT_POP     = 9;
endpackage
`default_nettype wire

// file: logic/ncirq_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ncirq_evt_if;
  logic [14:0] event_pulse;
  logic [14:0] clear_bits;
  logic [14:0] source;
  modport producer (output event_pulse);
  modport consumer (input event_pulse);
  modport holder   (input event_pulse, input clear_bits, output source);
  modport owner    (output clear_bits, input source);
endinterface
`default_nettype wire

// file: logic/ncirq_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Derives level-change events from the FIFO status levels.
module ncirq_edge (
  input  wire logic                               mclk_in,   // System clock.
  input  wire logic                               srst_in,   // Sync reset.
  input  wire logic                               rx_full_in,  // Receive FIFO full.
  input  wire logic                               rx_empty_in, // Receive FIFO empty.
  input  wire logic                               tx_full_in,  // Transmit FIFO full.
  input  wire logic                               tx_empty_in, // Transmit FIFO empty.
  input  wire logic [ncirq_pkg::LEVEL_W-1:0]      rx_level_in, // Receive bytes held.
  input  wire logic [ncirq_pkg::LEVEL_W-1:0]      tx_space_in, // Transmit free bytes.
  input  wire logic [ncirq_pkg::LEVEL_W-1:0]      rx_thresh_in, // Receive threshold.
  input  wire logic [ncirq_pkg::LEVEL_W-1:0]      tx_thresh_in, // Transmit threshold.
  output logic [5:0]                              pulse_out    // Events, bits 5..0.
);
  logic [5:0] cond;
  logic [5:0] cond_q;
  always_comb begin
    cond[ncirq_pkg::BIT_TX_EMPTY]    = tx_empty_in;
    cond[ncirq_pkg::BIT_TX_THRESH]   = tx_space_in > tx_thresh_in;
    cond[ncirq_pkg::BIT_TX_NONFULL]  = !tx_full_in;
    cond[ncirq_pkg::BIT_RX_NONEMPTY] = !rx_empty_in;
    cond[ncirq_pkg::BIT_RX_THRESH]   = rx_level_in > rx_thresh_in;
    cond[ncirq_pkg::BIT_RX_FULL]     = rx_full_in;
  end
  // The previous value starts with every condition set, so reset causes no event.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cond_q <= 6'h3F;
    end else begin
      cond_q <= cond;
    end
  end
  // Only rising conditions are events; a steady level never re-fires after a clear.
  assign pulse_out = cond & ~cond_q;
endmodule
`default_nettype wire

// file: dv/ncirq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ncirq_top_tb;
  logic        mclk_in  = 1'b0;
  logic        srst_in  = 1'b1;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic [7:0]  addr_in  = 8'h00;
  logic [31:0] wdata_in = 32'h00000000;
  logic [31:0] rdata_out;
  logic        irq_out;
  logic        rx_full  = 1'b0;
  logic        rx_empty = 1'b1;
  logic        tx_full  = 1'b1;
  logic        tx_empty = 1'b0;
  logic [11:0] rx_level = 12'h000;
  logic [11:0] tx_space = 12'h000;
  logic [14:6] ev       = 9'h000;
  logic        acc      = 1'b0;
  logic        acc_dir  = 1'b0;
  logic        acc_word = 1'b0;
  logic [1:0]  acc_ptr  = 2'h0;
  logic        rd_d     = 1'b0;
  logic [7:0]  seed     = 8'h61;
  logic [31:0] src;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          compares  = 0;

  ncirq_top ncirq_top_i (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .rx_full_in(rx_full), .rx_empty_in(rx_empty), .tx_full_in(tx_full),
    .tx_empty_in(tx_empty), .rx_level_in(rx_level), .tx_space_in(tx_space),
    .bus_push_ovr_in(ev[6]), .bus_pop_und_in(ev[7]), .bus_acc_in(acc),
    .bus_acc_dir_in(acc_dir), .bus_acc_word_in(acc_word), .bus_byte_ptr_in(acc_ptr),
    .ext_push_err_in(ev[8]), .ext_pop_err_in(ev[9]), .blk_read_done_in(ev[10]),
    .blk_write_done_in(ev[11]), .par_ready_in(ev[12]), .ecc_check_done_in(ev[13]),
    .corr_data_done_in(ev[14]));

  initial forever #2 mclk_in = ~mclk_in;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // One bus cycle; event pulses may ride along with a write in the same cycle.
  task automatic cyc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [14:6] e);
    @(posedge mclk_in);
    wr_in <= w; addr_in <= a; wdata_in <= d; ev <= e;
    @(posedge mclk_in);
    wr_in <= 1'b0; ev <= 9'h000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1'b1, a, d, 9'h000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] expv);
    exp_q.push_back(expv);
    @(posedge mclk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask

  task automatic irq_chk(input logic expv);
    repeat (3) @(posedge mclk_in);
    #1 chk({31'h0, irq_out}, {31'h0, expv});
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge mclk_in) begin
    if (rd_d) chk(rdata_out, exp_q.pop_front());
    rd_d <= rd_in;
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    rd(ncirq_pkg::OFF_MASK, 32'h00007FFF);
    rd(ncirq_pkg::OFF_SOURCE, 32'h00000000);
    rd(ncirq_pkg::OFF_CLEAR, 32'h00000000);
    rd(8'h10, 32'h00000000);
    for (int b = 6; b < 15; b++) begin
      cyc(1'b0, 8'h00, 32'h0, 9'h001 << (b - 6));
      rd(ncirq_pkg::OFF_SOURCE, 32'h1 << b);
      irq_chk(1'b0);
      wr(ncirq_pkg::OFF_MASK, ~(32'h1 << b) & 32'h00007FFF);
      irq_chk(1'b1);
      wr(ncirq_pkg::OFF_CLEAR, ~(32'h1 << b) & 32'h00007FFF);
      rd(ncirq_pkg::OFF_SOURCE, 32'h1 << b);
      wr(ncirq_pkg::OFF_CLEAR, 32'h1 << b);
      irq_chk(1'b0);
      wr(ncirq_pkg::OFF_MASK, 32'hFFFFFFFF);
    end
    wr(ncirq_pkg::OFF_THRESH, 32'h000A0014);
    rd(ncirq_pkg::OFF_THRESH, 32'h000A0014);
    @(posedge mclk_in);
    tx_space <= 12'h014; rx_level <= 12'h00A;
    repeat (3) @(posedge mclk_in);
    rd(ncirq_pkg::OFF_SOURCE, 32'h00000000);
    src = 32'h0;
    for (int b = 0; b < 6; b++) begin
      seed = lfsr_next(seed);
      @(posedge mclk_in);
      case (b)
        0: tx_empty <= 1'b1;
        1: tx_space <= 12'h015 + {8'h00, seed[3:0]};
        2: tx_full  <= 1'b0;
        3: rx_empty <= 1'b0;
        4: rx_level <= 12'h00B + {8'h00, seed[3:0]};
        default: rx_full <= 1'b1;
      endcase
      repeat (3) @(posedge mclk_in);
      src = src | (32'h1 << b);
      rd(ncirq_pkg::OFF_SOURCE, src);
    end
    wr(ncirq_pkg::OFF_CLEAR, 32'h00007FFF);
    rd(ncirq_pkg::OFF_SOURCE, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      acc <= 1'b1; acc_dir <= ~i[0]; acc_word <= (i < 3); acc_ptr <= (i == 2) ? 2'h0 : 2'h2;
      @(posedge mclk_in);
      acc <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rd(ncirq_pkg::OFF_SOURCE, (i < 2) ? (32'h40 << i) : 32'h0);
      wr(ncirq_pkg::OFF_CLEAR, 32'h00007FFF);
    end
    cyc(1'b1, ncirq_pkg::OFF_CLEAR, 32'h00000400, 9'h010);
    rd(ncirq_pkg::OFF_SOURCE, 32'h00000400);
    seed = lfsr_next(seed);
    wr(ncirq_pkg::OFF_MASK, {4{seed}});
    rd(ncirq_pkg::OFF_MASK, {4{seed}} & 32'h00007FFF);
    wr(ncirq_pkg::OFF_MASK, 32'hFFFF0000);
    rd(ncirq_pkg::OFF_MASK, 32'h00000000);
    irq_chk(1'b1);
    @(posedge mclk_in);
    srst_in <= 1'b1;
    @(posedge mclk_in);
    srst_in <= 1'b0;
    rd(ncirq_pkg::OFF_MASK, 32'h00007FFF);
    rd(ncirq_pkg::OFF_SOURCE, 32'h00000000);
    irq_chk(1'b0);
    repeat (3) @(posedge mclk_in);
    tally_and_finish();
  end
endmodule
`default_nettype wire
